// ### ugps_pkg.sv
package ugps_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int DOT_W = 5;
  localparam int CODE_W = 8;
  localparam int GLYPH_ADDR_W = 6;
  localparam int GLYPH_DEPTH = 64;
  localparam int TEXT_ADDR_W = 7;
  localparam int TEXT_DEPTH = 128;
  localparam int ROW_W = 4;

  // ***************************************************************
  // Glyph addressing
  // ***************************************************************
  localparam logic [ROW_W-1:0] CURSOR_ROW_SHORT = 4'h7;
  localparam logic [ROW_W-1:0] CURSOR_ROW_TALL = 4'hA;
  localparam logic [3:0] USER_CODE_HI = 4'h0;
  localparam logic [DOT_W-1:0] CURSOR_DOTS = 5'h1F;
  localparam logic [DOT_W-1:0] DARK_DOTS = 5'h00;
  localparam logic [TEXT_ADDR_W-1:0] PTR_RESET = 7'h00;
  localparam logic [TEXT_ADDR_W-1:0] PTR_STEP = 7'h01;
  localparam logic [TEXT_ADDR_W-1:0] GLYPH_PTR_MASK = 7'h3F;

  typedef enum logic {TGT_GLYPH, TGT_TEXT} ugps_target_e;

  typedef struct packed {
    logic addrLoad;
    logic [TEXT_ADDR_W-1:0] addrVal;
    ugps_target_e target;
    logic write;
    logic read;
    logic [CODE_W-1:0] data;
  } ugps_host_s;

  typedef struct packed {
    logic req;
    logic [TEXT_ADDR_W-1:0] textAddr;
    logic [ROW_W-1:0] rowSel;
    logic cursorOn;
  } ugps_fetch_s;

  typedef struct packed {
    logic valid;
    logic userGlyph;
    logic [DOT_W-1:0] dots;
  } ugps_row_s;

endpackage

// ### ugps_store.sv
`timescale 1ns/10ps
`default_nettype none

module ugps_store #(
  parameter int TEXT_DEPTH = ugps_pkg::TEXT_DEPTH,
  parameter int GLYPH_DEPTH = ugps_pkg::GLYPH_DEPTH
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire ugps_pkg::ugps_host_s hostCmd,
  input wire logic entryUp,
  input wire logic fontTall,
  input wire ugps_pkg::ugps_fetch_s fetchIn,
  output ugps_pkg::ugps_row_s rowOut,
  output logic [ugps_pkg::CODE_W-1:0] hostRdData,
  output logic hostRdValid,
  output logic [ugps_pkg::TEXT_ADDR_W-1:0] ramAddressPointer
);

  // ***************************************************************
  // Parameter checks
  // ***************************************************************
  if (TEXT_DEPTH != (1 << ugps_pkg::TEXT_ADDR_W)) begin : g_badText
    $error("text depth must match the pointer width");
  end
  if (GLYPH_DEPTH != (1 << ugps_pkg::GLYPH_ADDR_W)) begin : g_badGlyph
    $error("glyph depth must match the glyph address width");
  end

  // ***************************************************************
  // Memories
  // ***************************************************************
  logic [ugps_pkg::CODE_W-1:0] displayTextRam [TEXT_DEPTH];
  logic [ugps_pkg::DOT_W-1:0] userGlyphRam [GLYPH_DEPTH];

  logic ptrOnlyLoad;
  logic glyphWr;
  logic textWr;
  logic anyAccess;
  logic [ugps_pkg::GLYPH_ADDR_W-1:0] glyphPtr;

  assign ptrOnlyLoad = hostCmd.addrLoad;
  assign glyphWr = !ptrOnlyLoad && hostCmd.write && hostCmd.target == ugps_pkg::TGT_GLYPH;
  assign textWr = !ptrOnlyLoad && hostCmd.write && hostCmd.target == ugps_pkg::TGT_TEXT;
  assign anyAccess = !ptrOnlyLoad && (hostCmd.write || hostCmd.read);
  assign glyphPtr = ramAddressPointer[ugps_pkg::GLYPH_ADDR_W-1:0];

  // Glyph writes keep only the five dot bits and drop the upper data bits; text writes keep all eight
  always_ff @(posedge core_clk) begin
    if (glyphWr) begin
      userGlyphRam[glyphPtr] <= hostCmd.data[ugps_pkg::DOT_W-1:0];
    end
    if (textWr) begin
      displayTextRam[ramAddressPointer] <= hostCmd.data;
    end
  end

  // ***************************************************************
  // Address pointer and host read
  // ***************************************************************
  logic [ugps_pkg::TEXT_ADDR_W-1:0] ptr_nxt;
  logic [ugps_pkg::TEXT_ADDR_W-1:0] stepped;
  logic [ugps_pkg::CODE_W-1:0] rdData_nxt;
  logic rdValid_nxt;

  always_comb begin
    stepped = entryUp ? ramAddressPointer + ugps_pkg::PTR_STEP
                      : ramAddressPointer - ugps_pkg::PTR_STEP;
    if (hostCmd.target == ugps_pkg::TGT_GLYPH) begin
      stepped = stepped & ugps_pkg::GLYPH_PTR_MASK;
    end
    ptr_nxt = ramAddressPointer;
    rdData_nxt = hostRdData;
    rdValid_nxt = 1'b0;
    if (ptrOnlyLoad) begin
      ptr_nxt = hostCmd.addrVal;
    end else if (anyAccess) begin
      ptr_nxt = stepped;
    end
    if (anyAccess && !hostCmd.write && hostCmd.read) begin
      rdValid_nxt = 1'b1;
      if (hostCmd.target == ugps_pkg::TGT_GLYPH) begin
        rdData_nxt = {3'h0, userGlyphRam[glyphPtr]};
      end else begin
        rdData_nxt = displayTextRam[ramAddressPointer];
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ramAddressPointer <= ugps_pkg::PTR_RESET;
      hostRdData <= 8'h00;
      hostRdValid <= 1'b0;
    end else begin
      ramAddressPointer <= ptr_nxt;
      hostRdData <= rdData_nxt;
      hostRdValid <= rdValid_nxt;
    end
  end

  // ***************************************************************
  // Glyph fetch for the scan
  // ***************************************************************
  logic [ugps_pkg::CODE_W-1:0] curCode;
  logic userSel;
  logic [ugps_pkg::GLYPH_ADDR_W-1:0] glyphAddr;
  logic [ugps_pkg::DOT_W-1:0] glyphWord;
  logic cursorRow;
  logic [ugps_pkg::DOT_W-1:0] litDots;
  ugps_pkg::ugps_row_s row_nxt;

  assign curCode = displayTextRam[fetchIn.textAddr];
  assign userSel = curCode[7:4] == ugps_pkg::USER_CODE_HI;

  // Code bit 3 never reaches the address, so xxxx1xxx aliases xxxx0xxx
  always_comb begin
    if (fontTall) begin
      glyphAddr = {curCode[2:1], fetchIn.rowSel};
      cursorRow = fetchIn.rowSel == ugps_pkg::CURSOR_ROW_TALL;
    end else begin
      glyphAddr = {curCode[2:0], fetchIn.rowSel[2:0]};
      cursorRow = fetchIn.rowSel[2:0] == ugps_pkg::CURSOR_ROW_SHORT[2:0];
    end
  end

  assign glyphWord = userGlyphRam[glyphAddr];

  // Bit 4 leaves as the leftmost dot; each dot ORs with the cursor
  for (genvar b = 0; b < ugps_pkg::DOT_W; b++) begin : g_dot
    assign litDots[b] = glyphWord[b] | (cursorRow & fetchIn.cursorOn);
  end

  always_comb begin
    row_nxt = rowOut;
    row_nxt.valid = fetchIn.req;
    if (fetchIn.req) begin
      row_nxt.userGlyph = userSel;
      row_nxt.dots = userSel ? litDots : ugps_pkg::DARK_DOTS;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rowOut <= '0;
    end else begin
      rowOut <= row_nxt;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  logic lastWrValid_r;
  logic [ugps_pkg::GLYPH_ADDR_W-1:0] lastWrAddr_r;
  logic [ugps_pkg::DOT_W-1:0] lastWrData_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      lastWrValid_r <= 1'b0;
      lastWrAddr_r <= 6'h00;
      lastWrData_r <= 5'h00;
    end else begin
      lastWrValid_r <= glyphWr;
      lastWrAddr_r <= glyphPtr;
      lastWrData_r <= hostCmd.data[ugps_pkg::DOT_W-1:0];
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  property p_ptrUp;
    anyAccess && entryUp && hostCmd.target == ugps_pkg::TGT_GLYPH
      |=> ramAddressPointer == (($past(ramAddressPointer) + 7'h01) & 7'h3F);
  endproperty
  a_ptrUp: assert property (p_ptrUp) else $error("pointer did not step up");

  property p_ptrDown;
    anyAccess && !entryUp && hostCmd.target == ugps_pkg::TGT_TEXT
      |=> ramAddressPointer == $past(ramAddressPointer) - 7'h01;
  endproperty
  a_ptrDown: assert property (p_ptrDown) else $error("pointer did not step down");

  property p_overwrite;
    lastWrValid_r |-> userGlyphRam[lastWrAddr_r] == lastWrData_r;
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("glyph row not replaced");

  property p_slotMap;
    fetchIn.req && !fontTall |-> glyphAddr[5:3] == curCode[2:0] && glyphAddr[2:0] == fetchIn.rowSel[2:0];
  endproperty
  a_slotMap: assert property (p_slotMap) else $error("short glyph address wrong");

  property p_tallMap;
    fetchIn.req && fontTall |-> glyphAddr == {curCode[2:1], fetchIn.rowSel};
  endproperty
  a_tallMap: assert property (p_tallMap) else $error("tall glyph address wrong");

  property p_userSelect;
    fetchIn.req |=> rowOut.valid && rowOut.userGlyph == ($past(curCode[7:4]) == 4'h0);
  endproperty
  a_userSelect: assert property (p_userSelect) else $error("user glyph selection wrong");

  property p_fixedDark;
    fetchIn.req && !userSel |=> rowOut.dots == 5'h00 && !rowOut.userGlyph;
  endproperty
  a_fixedDark: assert property (p_fixedDark) else $error("fixed font code not dark");

  property p_cursorOr;
    fetchIn.req && userSel && cursorRow && fetchIn.cursorOn |=> rowOut.dots == 5'h1F;
  endproperty
  a_cursorOr: assert property (p_cursorOr) else $error("cursor not ORed");

  property p_storedDots;
    fetchIn.req && userSel && !fetchIn.cursorOn |=> rowOut.dots == $past(glyphWord);
  endproperty
  a_storedDots: assert property (p_storedDots) else $error("dots differ from stored row");

  property p_bit3Alias;
    fetchIn.req |-> glyphAddr == (fontTall ? {curCode[2:1], fetchIn.rowSel}
                                           : {curCode[2:0], fetchIn.rowSel[2:0]});
  endproperty
  a_bit3Alias: assert property (p_bit3Alias) else $error("code bit 3 reached address");

  property p_readBack;
    anyAccess && !hostCmd.write && hostCmd.read |=> hostRdValid;
  endproperty
  a_readBack: assert property (p_readBack) else $error("read answer timing wrong");

  property p_validPulse;
    !fetchIn.req |=> !rowOut.valid;
  endproperty
  a_validPulse: assert property (p_validPulse) else $error("row valid without a fetch");

  property p_rdPulse;
    !(anyAccess && !hostCmd.write && hostCmd.read) |=> !hostRdValid;
  endproperty
  a_rdPulse: assert property (p_rdPulse) else $error("read valid without a read");

  property p_ptrLoad;
    hostCmd.addrLoad |=> ramAddressPointer == $past(hostCmd.addrVal);
  endproperty
  a_ptrLoad: assert property (p_ptrLoad) else $error("pointer load lost");

  property p_ptrDownGlyph;
    anyAccess && !entryUp && hostCmd.target == ugps_pkg::TGT_GLYPH
      |=> ramAddressPointer == (($past(ramAddressPointer) - 7'h01) & 7'h3F);
  endproperty
  a_ptrDownGlyph: assert property (p_ptrDownGlyph) else $error("glyph pointer did not step down");

  property p_ptrUpText;
    anyAccess && entryUp && hostCmd.target == ugps_pkg::TGT_TEXT
      |=> ramAddressPointer == $past(ramAddressPointer) + 7'h01;
  endproperty
  a_ptrUpText: assert property (p_ptrUpText) else $error("text pointer did not step up");

  property p_rdHighZero;
    anyAccess && !hostCmd.write && hostCmd.read && hostCmd.target == ugps_pkg::TGT_GLYPH
      |=> hostRdData[7:5] == 3'h0;
  endproperty
  a_rdHighZero: assert property (p_rdHighZero) else $error("glyph read upper bits not zero");

  property p_rdHold;
    !(anyAccess && !hostCmd.write && hostCmd.read) |=> $stable(hostRdData);
  endproperty
  a_rdHold: assert property (p_rdHold) else $error("read data changed without a read");

  property p_rowHold;
    !fetchIn.req |=> $stable(rowOut.dots) && $stable(rowOut.userGlyph);
  endproperty
  a_rowHold: assert property (p_rowHold) else $error("row changed without a fetch");

  property p_shortCursor;
    fetchIn.req && !fontTall && userSel && fetchIn.rowSel[2:0] == 3'h7 && fetchIn.cursorOn
      |=> rowOut.dots == 5'h1F;
  endproperty
  a_shortCursor: assert property (p_shortCursor) else $error("short cursor row not lit");

  property p_tallCursor;
    fetchIn.req && fontTall && userSel && fetchIn.rowSel == 4'hA && fetchIn.cursorOn
      |=> rowOut.dots == 5'h1F;
  endproperty
  a_tallCursor: assert property (p_tallCursor) else $error("tall cursor row not lit");

  property p_eighthLit;
    fetchIn.req && !fontTall && userSel && fetchIn.rowSel[2:0] == 3'h7
      |=> (rowOut.dots & $past(glyphWord)) == $past(glyphWord);
  endproperty
  a_eighthLit: assert property (p_eighthLit) else $error("stored eighth row dot dark");

  c_userFetch: cover property (fetchIn.req && userSel ##1 rowOut.valid);
  c_cursorRow: cover property (fetchIn.req && userSel && cursorRow && fetchIn.cursorOn);
  c_tallFetch: cover property (fetchIn.req && fontTall && userSel);
  c_writeThenRead: cover property (glyphWr ##1 hostCmd.read);

endmodule

`default_nettype wire

// ### ugps_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module ugps_host_model (
  input wire logic core_clk,
  output ugps_pkg::ugps_host_s hostCmd
);
  initial hostCmd = '0;
  // One access, held across the edge that takes it
  task automatic access(input logic ld, input logic [6:0] a, input ugps_pkg::ugps_target_e t,
                        input logic w, input logic r, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    hostCmd = '{addrLoad: ld, addrVal: a, target: t, write: w, read: r, data: d};
    @(posedge core_clk);
    #1;
    // Released addrVal and data show the inverse of the last value; target is kept, load/write/read go low
    hostCmd = '{addrLoad: 1'h0, addrVal: ~a, target: t, write: 1'h0, read: 1'h0, data: ~d};
  endtask
  // Eight rows of one 5x8 slot; high data bits set to show they are dropped
  task automatic write_glyph(input logic [2:0] slot, input logic lit);
    logic [4:0] row;
    access(1'h1, {1'h0, slot, 3'h0}, ugps_pkg::TGT_GLYPH, 1'h0, 1'h0, 8'h00);
    for (int i = 0; i < 8; i++) begin
      row = {slot[1:0], 3'(i)} ^ 5'h15;
      if (i == 7) row = lit ? 5'h01 : 5'h00;
      access(1'h0, 7'h00, ugps_pkg::TGT_GLYPH, 1'h1, 1'h0, {3'h7, row});
    end
  endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic core_clk = 1'h0;
  logic rst_n = 1'h0;
  logic entryUp = 1'h1;
  logic fontTall = 1'h0;
  ugps_pkg::ugps_fetch_s fetchIn = '0;
  ugps_pkg::ugps_host_s hostCmd;
  ugps_pkg::ugps_row_s rowOut;
  logic [7:0] hostRdData;
  logic hostRdValid;
  logic [6:0] ramAddressPointer;
  int err_count = 0;
  int checks_done = 0;
  always #2 core_clk = ~core_clk;
  ugps_host_model host (.core_clk(core_clk), .hostCmd(hostCmd));
  ugps_store dut (.core_clk(core_clk), .rst_n(rst_n), .hostCmd(hostCmd), .entryUp(entryUp),
    .fontTall(fontTall), .fetchIn(fetchIn), .rowOut(rowOut), .hostRdData(hostRdData),
    .hostRdValid(hostRdValid), .ramAddressPointer(ramAddressPointer));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [4:0] pat(input logic [2:0] s, input logic [2:0] r);
    return {s[1:0], r} ^ 5'h15;
  endfunction
  // Expected six bits are {userGlyph, dots}; valid must be high one cycle after req
  task automatic fetch(input logic [6:0] a, input logic [3:0] row, input logic cur, input logic [5:0] exp);
    @(posedge core_clk);
    #1;
    fetchIn = '{req: 1'h1, textAddr: a, rowSel: row, cursorOn: cur};
    @(posedge core_clk);
    #1;
    fetchIn = '{req: 1'h0, textAddr: ~a, rowSel: ~row, cursorOn: ~cur};
    check({1'h0, rowOut.valid, rowOut.userGlyph, rowOut.dots}, {2'h1, exp});
  endtask
  task automatic test_reset;
    repeat (3) @(posedge core_clk);
    check({hostRdValid, ramAddressPointer}, 8'h00);
    check(hostRdData, 8'h00);
    check({1'h0, rowOut}, 8'h00);
    #1 rst_n = 1'h1;
    $display("test_reset done");
  endtask
  task automatic test_host;
    host.access(1'h1, 7'h08, ugps_pkg::TGT_GLYPH, 1'h0, 1'h0, 8'h00);
    check({1'h0, ramAddressPointer}, 8'h08);
    host.access(1'h0, 7'h00, ugps_pkg::TGT_GLYPH, 1'h1, 1'h0, 8'hFF);
    check({1'h0, ramAddressPointer}, 8'h09);
    host.access(1'h1, 7'h08, ugps_pkg::TGT_GLYPH, 1'h0, 1'h0, 8'h00);
    host.access(1'h0, 7'h00, ugps_pkg::TGT_GLYPH, 1'h0, 1'h1, 8'h00);
    check({hostRdValid, ramAddressPointer}, 8'h89);
    check(hostRdData, 8'h1F);
    entryUp = 1'h0;
    host.access(1'h1, 7'h00, ugps_pkg::TGT_GLYPH, 1'h0, 1'h0, 8'h00);
    host.access(1'h0, 7'h00, ugps_pkg::TGT_GLYPH, 1'h0, 1'h1, 8'h00);
    check({hostRdValid, ramAddressPointer}, 8'hBF);
    entryUp = 1'h1;
    host.access(1'h1, 7'h7F, ugps_pkg::TGT_TEXT, 1'h0, 1'h0, 8'h00);
    host.access(1'h0, 7'h00, ugps_pkg::TGT_TEXT, 1'h1, 1'h0, 8'h00);
    check({hostRdValid, ramAddressPointer}, 8'h00);
    entryUp = 1'h0;
    host.access(1'h0, 7'h00, ugps_pkg::TGT_TEXT, 1'h1, 1'h0, 8'h00);
    check({1'h0, ramAddressPointer}, 8'h7F);
    entryUp = 1'h1;
    $display("test_host done");
  endtask
  task automatic test_short;
    logic [7:0] codes [6];
    codes = '{8'h08, 8'h00, 8'h10, 8'h07, 8'h06, 8'h01};
    host.access(1'h1, 7'h00, ugps_pkg::TGT_TEXT, 1'h0, 1'h0, 8'h00);
    for (int i = 0; i < 6; i++) host.access(1'h0, 7'h00, ugps_pkg::TGT_TEXT, 1'h1, 1'h0, codes[i]);
    for (int s = 0; s < 8; s++) host.write_glyph(3'(s), s[0]);
    fetch(7'h00, 4'h3, 1'h1, {1'h1, pat(3'h0, 3'h3)});
    fetch(7'h01, 4'h3, 1'h0, {1'h1, pat(3'h0, 3'h3)});
    fetch(7'h05, 4'h3, 1'h0, {1'h1, pat(3'h1, 3'h3)});
    fetch(7'h05, 4'h0, 1'h0, {1'h1, pat(3'h1, 3'h0)});
    fetch(7'h02, 4'h3, 1'h1, 6'h00);
    fetch(7'h01, 4'h7, 1'h1, 6'h3F);
    fetch(7'h05, 4'h7, 1'h0, 6'h21);
    fetch(7'h00, 4'h7, 1'h0, 6'h20);
    $display("test_short done");
  endtask
  task automatic test_tall;
    fontTall = 1'h1;
    fetch(7'h03, 4'hA, 1'h0, {1'h1, pat(3'h7, 3'h2)});
    fetch(7'h03, 4'hA, 1'h1, 6'h3F);
    fetch(7'h04, 4'h2, 1'h1, {1'h1, pat(3'h6, 3'h2)});
    fontTall = 1'h0;
    $display("test_tall done");
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    test_reset;
    test_host;
    test_short;
    test_tall;
    test_done;
  end
endmodule
`default_nettype wire
